// *** hw/cmc_meas_seq.sv ***
// Measurement sequencer running on the internal oscillator clock.
// Assumes the request toggle and the settings come from the system domain and that
// the settings stay still from the toggle until the done toggle returns.
`timescale 1ns/1ps
module cmc_meas_seq #(
	parameter int AXIS_CYC = cmc_pkg::AXIS_CYC
) (
	input  wire logic             osc_clk,
	input  wire logic             reset,
	input  wire logic             req_tgl,
	input  cmc_pkg::cmc_cfg_t     cfg,
	input  wire logic [7:0]       adc_data,
	output logic                  done_tgl,
	output logic                  busy,
	output cmc_pkg::cmc_res_t     res,
	output logic [2:0]            axis_selector,
	output logic [3:0]            gain_code,
	output logic [7:0]            dac_code,
	output logic                  drive_en
);

	localparam int CW = $clog2(AXIS_CYC) + 1;

	logic [8:0]           sync_q;
	logic                 req_seen_q;
	cmc_pkg::cmc_seq_st_t st_q;
	logic [CW-1:0]        cnt_q;
	logic [1:0]           axis_q;
	cmc_pkg::cmc_cfg_t    cfg_q;
	logic                 last_cyc;

	cmc_sync #(.W(9)) u_sync (
		.clk   (osc_clk),
		.reset (reset),
		.d     ({req_tgl, adc_data}),
		.q     (sync_q)
	);

	assign last_cyc = (cnt_q == CW'(AXIS_CYC - 1));

	// Sequence the three axes, each dwelling a fixed count before its result is taken.
	always_ff @(posedge osc_clk or posedge reset) begin
		if (reset) begin
			st_q       <= cmc_pkg::SEQ_IDLE;
			req_seen_q <= 1'b0;
			cnt_q      <= '0;
			axis_q     <= 2'h0;
			cfg_q      <= '0;
			res        <= '0;
			done_tgl   <= 1'b0;
			busy       <= 1'b0;
		end else begin
			case (st_q)
				cmc_pkg::SEQ_IDLE: begin
					if (sync_q[8] != req_seen_q) begin
						req_seen_q <= sync_q[8];
						cfg_q      <= cfg;
						cnt_q      <= '0;
						axis_q     <= 2'h0;
						busy       <= 1'b1;
						st_q       <= cmc_pkg::SEQ_RUN;
					end
				end
				cmc_pkg::SEQ_RUN: begin
					if (last_cyc) begin
						res.data[axis_q] <= sync_q[7:0];
						cnt_q            <= '0;
						if (axis_q == 2'h2) begin
							st_q <= cmc_pkg::SEQ_DONE;
						end else begin
							axis_q <= axis_q + 2'h1;
						end
					end else begin
						cnt_q <= cnt_q + CW'(1);
					end
				end
				cmc_pkg::SEQ_DONE: begin
					done_tgl <= ~done_tgl;
					busy     <= 1'b0;
					st_q     <= cmc_pkg::SEQ_IDLE;
				end
				default: st_q <= cmc_pkg::SEQ_IDLE;
			endcase
		end
	end

	// Analog controls are registered so the selector never glitches between axes.
	always_ff @(posedge osc_clk or posedge reset) begin
		if (reset) begin
			axis_selector <= 3'h1;
			gain_code     <= cmc_pkg::GAIN_RST;
			dac_code      <= cmc_pkg::DAC_RST;
			drive_en      <= 1'b0;
		end else begin
			axis_selector <= 3'h1 << axis_q;
			gain_code     <= cfg_q.gain[axis_q];
			dac_code      <= cfg_q.dac[axis_q];
			drive_en      <= (st_q == cmc_pkg::SEQ_RUN);
		end
	end

	default clocking cb @(posedge osc_clk); endclocking
	default disable iff (reset);

	sequence s_last_axis_end;
		st_q == cmc_pkg::SEQ_RUN && last_cyc && axis_q == 2'h2;
	endsequence

	sequence s_power_down;
		st_q == cmc_pkg::SEQ_DONE ##1 (st_q == cmc_pkg::SEQ_IDLE && !busy) ##1 !drive_en;
	endsequence

	property p_onehot;
		$onehot(axis_selector);
	endproperty
	a_onehot: assert property (p_onehot) else $error("axis selector not one-hot");

	property p_auto_pdn;
		s_last_axis_end |=> s_power_down;
	endproperty
	a_auto_pdn: assert property (p_auto_pdn) else $error("no power-down after run");

	property p_count;
		(st_q == cmc_pkg::SEQ_RUN && !last_cyc) |=> cnt_q == $past(cnt_q) + CW'(1);
	endproperty
	a_count: assert property (p_count) else $error("dwell counter skipped");

endmodule : cmc_meas_seq

// *** hw/cmc_sync.sv ***
// Two-flop synchroniser for a vector of independent levels.
// Assumes each bit is a level that is held long enough to be seen.
`timescale 1ns/1ps
module cmc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);

	logic [W-1:0] meta_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			meta_q <= '0;
			q      <= '0;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule : cmc_sync

// *** hw/cmc_top.sv ***
// Compass measurement control: two-wire serial slave with register map, calibration
// store access, interrupt, and handover of measurements to the oscillator domain.
// Assumes pins arrive asynchronously, the calibration store answers reads in the
// same cycle, and the internal oscillator runs while its enable is high.
`timescale 1ns/1ps
module cmc_top #(
	parameter logic [4:0] ADDR_HI  = cmc_pkg::SLV_ADDR_HI_DFLT,
	parameter int         AXIS_CYC = cmc_pkg::AXIS_CYC
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       internal_oscillator_clk,
	input  wire logic       reset_active_low,
	input  wire logic       addr_strap_bit0,
	input  wire logic       addr_strap_bit1,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe,
	output logic            int_o,
	output logic            internal_oscillator_en,
	output logic [2:0]      axis_selector,
	output logic [3:0]      gain_amplifier_code,
	output logic [7:0]      dac_code,
	output logic            drive_en,
	input  wire logic [7:0] adc_data,
	output logic [5:0]      nvm_addr,
	input  wire logic [7:0] nvm_rdata,
	output logic            nvm_we,
	output logic [7:0]      nvm_wdata
);

	logic [4:0]               pin_s;
	logic                     scl_s;
	logic                     sda_s;
	logic                     pin_rst;
	logic                     scl_p_q;
	logic                     sda_p_q;
	logic                     scl_rise;
	logic                     scl_fall;
	logic                     start_c;
	logic                     stop_c;
	logic                     strap_done_q;
	logic [1:0]               slv_lo_q;
	cmc_pkg::cmc_i2c_st_t     st_q;
	logic [3:0]               bit_q;
	logic [7:0]               sh_q;
	logic [7:0]               tx_q;
	logic                     rw_q;
	logic                     first_q;
	logic                     nack_q;
	logic                     sda_oe_q;
	logic [7:0]               ptr_q;
	logic [7:0]               mode_q;
	cmc_pkg::cmc_cfg_t        cfg_q;
	cmc_pkg::cmc_res_t        res_q;
	logic                     drdy_q;
	logic                     busy_q;
	logic                     req_tgl_q;
	logic                     done_seen_q;
	logic                     osc_en_q;
	logic                     nvm_we_q;
	logic [7:0]               nvm_wdata_q;
	logic [1:0]               osc_s;
	logic                     done_ev;
	logic                     rx_done;
	logic                     rx_wr;
	logic                     rd_ld;
	logic                     rd_clr;
	logic [7:0]               rd_byte;
	logic                     seq_done_tgl;
	logic                     seq_busy;
	cmc_pkg::cmc_res_t        seq_res;

	// Every pin is synchronised before anything looks at it.
	cmc_sync #(.W(5)) u_pin_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({reset_active_low, addr_strap_bit1, addr_strap_bit0, scl_i, sda_i}),
		.q     (pin_s)
	);

	// Completion toggle and busy level coming back from the oscillator domain.
	cmc_sync #(.W(2)) u_osc_sync (
		.clk   (clk),
		.reset (reset),
		.d     ({seq_done_tgl, seq_busy}),
		.q     (osc_s)
	);

	assign pin_rst = ~pin_s[4];
	assign scl_s   = pin_s[1];
	assign sda_s   = pin_s[0];

	// Bus events from the synchronised lines; a data edge while the clock is high frames.
	assign scl_rise = scl_s & ~scl_p_q;
	assign scl_fall = ~scl_s & scl_p_q;
	assign start_c  = scl_s & scl_p_q & sda_p_q & ~sda_s;
	assign stop_c   = scl_s & scl_p_q & ~sda_p_q & sda_s;

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			scl_p_q <= 1'b1;
			sda_p_q <= 1'b1;
		end else begin
			scl_p_q <= scl_s;
			sda_p_q <= sda_s;
		end
	end

	// Straps are caught once the reset pin has been released, and again after each pin reset.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			strap_done_q <= 1'b0;
			slv_lo_q     <= 2'h0;
		end else if (pin_rst) begin
			strap_done_q <= 1'b0;
		end else if (!strap_done_q) begin
			strap_done_q <= 1'b1;
			slv_lo_q     <= pin_s[3:2];
		end
	end

	assign rx_done = scl_fall && st_q == cmc_pkg::I2C_RXB && bit_q == 4'h8;
	assign rx_wr   = rx_done && !first_q;
	assign rd_ld   = scl_fall && ((st_q == cmc_pkg::I2C_AACK && rw_q) ||
	                              (st_q == cmc_pkg::I2C_TACK && !nack_q));
	assign rd_clr  = rd_ld && ptr_q >= cmc_pkg::REG_DATA_BASE &&
	                 ptr_q < cmc_pkg::REG_MODE;
	assign done_ev = osc_s[1] != done_seen_q;

	// Read data for the current pointer; calibration bytes appear only in store mode.
	always_comb begin
		rd_byte = 8'h00;
		if (ptr_q == cmc_pkg::REG_STATUS) begin
			rd_byte = {6'h00, busy_q, drdy_q};
		end
		if (ptr_q == cmc_pkg::REG_MODE) begin
			rd_byte = mode_q;
		end
		for (int i = 0; i < cmc_pkg::NUM_AXES; i++) begin
			if (ptr_q == cmc_pkg::REG_DATA_BASE + 8'(i)) begin
				rd_byte = res_q.data[i];
			end
			if (ptr_q == cmc_pkg::REG_DAC_BASE + 8'(i)) begin
				rd_byte = cfg_q.dac[i];
			end
			if (ptr_q == cmc_pkg::REG_GAIN_BASE + 8'(i)) begin
				rd_byte = {4'h0, cfg_q.gain[i]};
			end
		end
		if (ptr_q >= cmc_pkg::NVM_BASE && mode_q == cmc_pkg::MODE_NVM) begin
			rd_byte = nvm_rdata;
		end
	end

	// Serial slave: bits are taken on clock rise and driven after clock fall.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			st_q     <= cmc_pkg::I2C_IDLE;
			bit_q    <= 4'h0;
			sh_q     <= 8'h00;
			tx_q     <= 8'h00;
			rw_q     <= 1'b0;
			first_q  <= 1'b0;
			nack_q   <= 1'b0;
			sda_oe_q <= 1'b0;
		end else if (pin_rst || stop_c) begin
			st_q     <= cmc_pkg::I2C_IDLE;
			sda_oe_q <= 1'b0;
		end else if (start_c) begin
			st_q     <= cmc_pkg::I2C_ADDR;
			bit_q    <= 4'h0;
			sda_oe_q <= 1'b0;
		end else if (scl_rise) begin
			if (st_q == cmc_pkg::I2C_ADDR || st_q == cmc_pkg::I2C_RXB) begin
				sh_q  <= {sh_q[6:0], sda_s};
				bit_q <= bit_q + 4'h1;
			end
			if (st_q == cmc_pkg::I2C_TACK) begin
				nack_q <= sda_s;
			end
		end else if (scl_fall) begin
			case (st_q)
				cmc_pkg::I2C_ADDR: begin
					if (bit_q == 4'h8) begin
						if (sh_q[7:1] == {ADDR_HI, slv_lo_q}) begin
							st_q     <= cmc_pkg::I2C_AACK;
							sda_oe_q <= 1'b1;
							rw_q     <= sh_q[0];
							first_q  <= ~sh_q[0];
						end else begin
							st_q <= cmc_pkg::I2C_IDLE;
						end
					end
				end
				cmc_pkg::I2C_AACK, cmc_pkg::I2C_TACK: begin
					if (rw_q && !(st_q == cmc_pkg::I2C_TACK && nack_q)) begin
						st_q     <= cmc_pkg::I2C_TXB;
						tx_q     <= rd_byte;
						sda_oe_q <= ~rd_byte[7];
						bit_q    <= 4'h1;
					end else if (!rw_q) begin
						st_q     <= cmc_pkg::I2C_RXB;
						sda_oe_q <= 1'b0;
						bit_q    <= 4'h0;
					end else begin
						st_q     <= cmc_pkg::I2C_IDLE;
						sda_oe_q <= 1'b0;
					end
				end
				cmc_pkg::I2C_RXB: begin
					if (bit_q == 4'h8) begin
						st_q     <= cmc_pkg::I2C_RACK;
						sda_oe_q <= 1'b1;
					end
				end
				cmc_pkg::I2C_RACK: begin
					st_q     <= cmc_pkg::I2C_RXB;
					sda_oe_q <= 1'b0;
					bit_q    <= 4'h0;
					first_q  <= 1'b0;
				end
				cmc_pkg::I2C_TXB: begin
					if (bit_q == 4'h8) begin
						st_q     <= cmc_pkg::I2C_TACK;
						sda_oe_q <= 1'b0;
					end else begin
						tx_q     <= {tx_q[6:0], 1'b0};
						sda_oe_q <= ~tx_q[6];
						bit_q    <= bit_q + 4'h1;
					end
				end
				default: st_q <= cmc_pkg::I2C_IDLE;
			endcase
		end
	end

	// Pointer loads from the first written byte and advances after each data byte.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			ptr_q <= 8'h00;
		end else if (pin_rst) begin
			ptr_q <= 8'h00;
		end else if (rx_done && first_q) begin
			ptr_q <= sh_q;
		end else if (rx_wr || rd_ld) begin
			ptr_q <= ptr_q + 8'h01;
		end
	end

	// Settings and mode; settings are frozen while a measurement is in flight so the
	// oscillator domain can take them without a wide crossing.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			mode_q    <= cmc_pkg::MODE_RST;
			cfg_q     <= {{3{cmc_pkg::GAIN_RST}}, {3{cmc_pkg::DAC_RST}}};
			busy_q    <= 1'b0;
			req_tgl_q <= 1'b0;
		end else if (pin_rst) begin
			mode_q    <= cmc_pkg::MODE_RST;
			cfg_q     <= {{3{cmc_pkg::GAIN_RST}}, {3{cmc_pkg::DAC_RST}}};
			busy_q    <= 1'b0;
		end else if (done_ev && busy_q) begin
			mode_q <= cmc_pkg::MODE_PDN;
			busy_q <= 1'b0;
		end else if (rx_wr && !busy_q && !osc_s[0]) begin
			if (ptr_q == cmc_pkg::REG_MODE) begin
				mode_q <= sh_q;
				if (sh_q == cmc_pkg::MODE_MEAS) begin
					busy_q    <= 1'b1;
					req_tgl_q <= ~req_tgl_q;
				end
			end
			for (int i = 0; i < cmc_pkg::NUM_AXES; i++) begin
				if (ptr_q == cmc_pkg::REG_DAC_BASE + 8'(i)) begin
					cfg_q.dac[i] <= sh_q;
				end
				if (ptr_q == cmc_pkg::REG_GAIN_BASE + 8'(i)) begin
					cfg_q.gain[i] <= sh_q[3:0];
				end
			end
		end
	end

	// Completion: results are taken when the toggle lands, already stable by then.
	// A completion in the same cycle as a data read keeps the ready flag set.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			done_seen_q <= 1'b0;
			res_q       <= '0;
			drdy_q      <= 1'b0;
		end else begin
			done_seen_q <= osc_s[1];
			if (pin_rst) begin
				res_q  <= '0;
				drdy_q <= 1'b0;
			end else begin
				if (done_ev && busy_q) begin
					res_q <= seq_res;
				end
				drdy_q <= (done_ev & busy_q) | (drdy_q & ~rd_clr);
			end
		end
	end

	// Oscillator enable and calibration store write strobe.
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			osc_en_q    <= 1'b0;
			nvm_we_q    <= 1'b0;
			nvm_wdata_q <= 8'h00;
		end else begin
			osc_en_q <= busy_q | osc_s[0];
			nvm_we_q <= rx_wr && !pin_rst && ptr_q >= cmc_pkg::NVM_BASE &&
			            mode_q == cmc_pkg::MODE_NVM;
			if (rx_wr) begin
				nvm_wdata_q <= sh_q;
			end
		end
	end

	cmc_meas_seq #(.AXIS_CYC(AXIS_CYC)) u_seq (
		.osc_clk       (internal_oscillator_clk),
		.reset         (reset),
		.req_tgl       (req_tgl_q),
		.cfg           (cfg_q),
		.adc_data      (adc_data),
		.done_tgl      (seq_done_tgl),
		.busy          (seq_busy),
		.res           (seq_res),
		.axis_selector (axis_selector),
		.gain_code     (gain_amplifier_code),
		.dac_code      (dac_code),
		.drive_en      (drive_en)
	);

	// Open-drain data line: only ever pulled low.
	assign sda_o                  = 1'b0;
	assign sda_oe                 = sda_oe_q;
	assign int_o                  = drdy_q;
	assign internal_oscillator_en = osc_en_q;
	assign nvm_addr               = ptr_q[5:0];
	assign nvm_we                 = nvm_we_q;
	assign nvm_wdata              = nvm_wdata_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	property p_strap;
		(strap_done_q && !pin_rst) |=> $stable(slv_lo_q);
	endproperty
	a_strap: assert property (p_strap) else $error("address straps changed");

	property p_pin_rst;
		pin_rst |=> (mode_q == cmc_pkg::MODE_RST && !drdy_q && !busy_q && ptr_q == 8'h00);
	endproperty
	a_pin_rst: assert property (p_pin_rst) else $error("pin reset left state");

	property p_int;
		(done_ev && busy_q && !pin_rst) |=> int_o ##1 (int_o || $past(rd_clr));
	endproperty
	a_int: assert property (p_int) else $error("completion not signalled");

	property p_osc;
		busy_q |=> internal_oscillator_en;
	endproperty
	a_osc: assert property (p_osc) else $error("oscillator off while busy");

	property p_gain;
		(rx_wr && !pin_rst && !busy_q && !osc_s[0] && !done_ev &&
		 ptr_q == cmc_pkg::REG_GAIN_BASE) |=> cfg_q.gain[0] == $past(sh_q[3:0]);
	endproperty
	a_gain: assert property (p_gain) else $error("gain code not stored");

	property p_res;
		(done_ev && busy_q && !pin_rst) |=> res_q == $past(seq_res);
	endproperty
	a_res: assert property (p_res) else $error("result not captured");

	property p_nvm;
		nvm_we |-> $past(mode_q) == cmc_pkg::MODE_NVM;
	endproperty
	a_nvm: assert property (p_nvm) else $error("store write outside store mode");

	property p_nvm_off;
		(rx_wr && ptr_q >= cmc_pkg::NVM_BASE && mode_q != cmc_pkg::MODE_NVM) |=> !nvm_we;
	endproperty
	a_nvm_off: assert property (p_nvm_off) else $error("store write not refused");

endmodule : cmc_top

// *** pkg/cmc_pkg.sv ***
// Package of the compass measurement control block: map offsets, mode codes,
// reset values, timing counts and the structs that carry settings and results.
// Assumes a single system clock plus a separately gated internal oscillator clock.
package cmc_pkg;

	// Register map seen over the serial bus.
	localparam logic [7:0] REG_STATUS    = 8'h00;
	localparam logic [7:0] REG_DATA_BASE = 8'h01;
	localparam logic [7:0] REG_MODE      = 8'h04;
	localparam logic [7:0] REG_DAC_BASE  = 8'h05;
	localparam logic [7:0] REG_GAIN_BASE = 8'h08;
	localparam logic [7:0] NVM_BASE      = 8'h40;

	// Mode register codes and reset values.
	localparam logic [7:0] MODE_MEAS = 8'h00;
	localparam logic [7:0] MODE_NVM  = 8'h02;
	localparam logic [7:0] MODE_PDN  = 8'h03;
	localparam logic [7:0] MODE_RST  = MODE_PDN;
	localparam logic [3:0] GAIN_RST  = 4'h0;
	localparam logic [7:0] DAC_RST   = 8'h80;

	// Upper five slave address bits; the value is arbitrary.
	localparam logic [4:0] SLV_ADDR_HI_DFLT = 5'h03;

	// Whole measurement time and oscillator period give the dwell per axis.
	localparam int NUM_AXES      = 3;
	localparam int MEAS_TIME_NS  = 12600000;
	localparam int OSC_PERIOD_NS = 64;
	localparam int AXIS_CYC      = MEAS_TIME_NS / (OSC_PERIOD_NS * NUM_AXES);

	// Settings handed to the oscillator domain at each request.
	typedef struct packed {
		logic [2:0][3:0] gain;
		logic [2:0][7:0] dac;
	} cmc_cfg_t;

	// Conversion results handed back at completion.
	typedef struct packed {
		logic [2:0][7:0] data;
	} cmc_res_t;

	// Serial slave states, Gray coded along the usual path.
	typedef enum logic [2:0] {
		I2C_IDLE = 3'h0,
		I2C_ADDR = 3'h1,
		I2C_AACK = 3'h3,
		I2C_RXB  = 3'h2,
		I2C_RACK = 3'h6,
		I2C_TXB  = 3'h7,
		I2C_TACK = 3'h5
	} cmc_i2c_st_t;

	// Sequencer states.
	typedef enum logic [1:0] {
		SEQ_IDLE = 2'h0,
		SEQ_RUN  = 2'h1,
		SEQ_DONE = 2'h3
	} cmc_seq_st_t;

endpackage : cmc_pkg

// *** verification/cmc_host_model.sv ***
// Host model on the two-wire serial bus: start, stop, byte and register tasks.
// Assumes an open-drain SDA resolved by the bench with a pull-up.
`timescale 1ns/1ps
module cmc_host_model #(
	parameter int H = 96
) (
	input  wire logic clk,
	output logic      scl,
	output logic      sda_drv,
	input  wire logic sda_line
);
	// The bus idles released and high.
	initial begin
		scl = 1'b1;
		sda_drv = 1'b1;
	end
	// Data moves a quarter of the low phase (H/4) after SCL falls so it never races the clock edge.
	task automatic bit_io(input logic b, output logic r);
		#(H/4);
		sda_drv = b;
		#(H*3/4);
		scl = 1'b1;
		#(H/2);
		r = sda_line;
		#(H/2);
		scl = 1'b0;
	endtask : bit_io
	task automatic start_c();
		#(H/4);
		sda_drv = 1'b1;
		#(H);
		scl = 1'b1;
		#(H);
		sda_drv = 1'b0;
		#(H);
		scl = 1'b0;
	endtask : start_c
	task automatic stop_c();
		#(H/4);
		sda_drv = 1'b0;
		#(H);
		scl = 1'b1;
		#(H);
		sda_drv = 1'b1;
		#(H);
	endtask : stop_c
	// The ninth bit is always released, so a read byte ends with a NACK.
	task automatic byte_io(input logic [7:0] w, output logic [7:0] r, output logic nak);
		for (int i = 7; i >= 0; i--) begin
			bit_io(w[i], r[i]);
		end
		bit_io(1'b1, nak);
	endtask : byte_io
	task automatic wr_reg(input logic [6:0] dev, input logic [7:0] p, d, output logic nak);
		logic [7:0] r;
		logic       n0, n1, n2;
		@(posedge clk);
		#1;
		start_c();
		byte_io({dev, 1'b0}, r, n0);
		byte_io(p, r, n1);
		byte_io(d, r, n2);
		stop_c();
		nak = n0 | n1 | n2;
	endtask : wr_reg
	// Pointer write, then repeated start and a single-byte read.
	task automatic rd_reg(input logic [6:0] dev, input logic [7:0] p, output logic [7:0] d,
		output logic nak);
		logic [7:0] r;
		logic       n0, n1, n2;
		@(posedge clk);
		#1;
		start_c();
		byte_io({dev, 1'b0}, r, n0);
		byte_io(p, r, n1);
		start_c();
		byte_io({dev, 1'b1}, r, n2);
		byte_io(8'hFF, d, n1);
		stop_c();
		nak = n0 | n2;
	endtask : rd_reg
endmodule : cmc_host_model

// *** verification/compass_measurement_control_test.sv ***
// Bench of the measurement control block: addressing, measurement, store and pin reset.
// Assumes the host model file; the oscillator clock here runs only while enabled.
`timescale 1ns/1ps
module compass_measurement_control_test;
	// Slave address: fixed upper bits, then the straps, which are tied 1 and 0 below.
	localparam logic [6:0] DEV = {cmc_pkg::SLV_ADDR_HI_DFLT, 2'b10};
	logic       clk, reset, osc_clk, rst_n_pin, strap0, strap1, scl, host_sda;
	logic       sda_oe, int_o, osc_en, drive_en, nak, nvm_we, we_seen;
	logic [2:0] axis;
	logic [3:0] gain;
	logic [7:0] dac, d;
	logic [5:0] nvm_addr;
	int         err_count, checks_done;
	wire logic  sda_line = host_sda & ~sda_oe;
	// Converter and store answer from fixed patterns so expectations are known.
	wire logic [7:0] adc = {5'h00, axis} * 8'h11;
	wire logic [7:0] nvm_rd = {2'h0, nvm_addr} ^ 8'hA5;

	cmc_top #(.AXIS_CYC(8)) dut (.clk(clk), .reset(reset), .internal_oscillator_clk(osc_clk),
		.reset_active_low(rst_n_pin), .addr_strap_bit0(strap0), .addr_strap_bit1(strap1),
		.scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe), .int_o(int_o),
		.internal_oscillator_en(osc_en), .axis_selector(axis), .gain_amplifier_code(gain),
		.dac_code(dac), .drive_en(drive_en), .adc_data(adc), .nvm_addr(nvm_addr),
		.nvm_rdata(nvm_rd), .nvm_we(nvm_we), .nvm_wdata());
	cmc_host_model host (.clk(clk), .scl(scl), .sda_drv(host_sda), .sda_line(sda_line));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// The oscillator stands still while its enable is low.
	initial begin
		osc_clk = 1'b0;
		#3;
		forever begin
			#32;
			osc_clk = osc_en ? ~osc_clk : 1'b0;
		end
	end
	task automatic chk(input logic [7:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	// Only one axis may be routed while the sensor is driven.
	always @(negedge osc_clk) begin
		if (drive_en === 1'b1) chk({7'h00, $onehot(axis)}, 8'h01);
	end
	// Any store write strobe during the run is remembered, since the host writes the store only outside store mode.
	always @(posedge clk) begin
		if (nvm_we !== 1'b0) we_seen = 1'b1;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	task automatic t_addr();
		host.rd_reg({cmc_pkg::SLV_ADDR_HI_DFLT, 2'b01}, cmc_pkg::REG_MODE, d, nak);
		chk({7'h00, nak}, 8'h01);
		host.rd_reg(DEV, cmc_pkg::REG_MODE, d, nak);
		chk({7'h00, nak}, 8'h00);
		chk(d, cmc_pkg::MODE_RST);
		$display("t_addr done");
	endtask : t_addr
	task automatic t_meas();
		host.wr_reg(DEV, cmc_pkg::REG_DAC_BASE, 8'h00, nak);
		host.wr_reg(DEV, cmc_pkg::REG_GAIN_BASE, 8'h0F, nak);
		host.wr_reg(DEV, cmc_pkg::REG_MODE, cmc_pkg::MODE_MEAS, nak);
		chk({7'h00, osc_en}, 8'h01);
		for (int i = 0; i < 2000 && drive_en !== 1'b1; i++) @(posedge clk);
		#1;
		chk({4'h0, gain}, 8'h0F);
		chk(dac, 8'h00);
		for (int i = 0; i < 5000 && int_o !== 1'b1; i++) @(posedge clk);
		repeat (10) @(posedge clk);
		#1;
		chk({6'h00, int_o, osc_en}, 8'h02);
		host.rd_reg(DEV, cmc_pkg::REG_STATUS, d, nak);
		chk(d, 8'h01);
		for (int i = 0; i < 3; i++) begin
			host.rd_reg(DEV, cmc_pkg::REG_DATA_BASE + 8'(i), d, nak);
			chk(d, 8'h11 << i);
		end
		chk({7'h00, int_o}, 8'h00);
		host.rd_reg(DEV, cmc_pkg::REG_MODE, d, nak);
		chk(d, cmc_pkg::MODE_PDN);
		$display("t_meas done");
	endtask : t_meas
	// The store is only read; a store write outside store mode must be refused.
	task automatic t_nvm();
		host.wr_reg(DEV, cmc_pkg::REG_MODE, cmc_pkg::MODE_NVM, nak);
		host.rd_reg(DEV, cmc_pkg::NVM_BASE + 8'h01, d, nak);
		chk(d, 8'hA4);
		host.wr_reg(DEV, cmc_pkg::REG_MODE, cmc_pkg::MODE_PDN, nak);
		host.wr_reg(DEV, cmc_pkg::NVM_BASE + 8'h01, 8'h3C, nak);
		chk({7'h00, we_seen}, 8'h00);
		host.rd_reg(DEV, cmc_pkg::NVM_BASE + 8'h01, d, nak);
		chk(d, 8'h00);
		$display("t_nvm done");
	endtask : t_nvm
	task automatic t_pin_reset();
		host.wr_reg(DEV, cmc_pkg::REG_DAC_BASE + 8'h01, 8'h5A, nak);
		host.rd_reg(DEV, cmc_pkg::REG_DAC_BASE + 8'h01, d, nak);
		chk(d, 8'h5A);
		@(posedge clk);
		#1;
		rst_n_pin = 1'b0;
		repeat (4) @(posedge clk);
		#1;
		rst_n_pin = 1'b1;
		repeat (10) @(posedge clk);
		host.rd_reg(DEV, cmc_pkg::REG_DAC_BASE + 8'h01, d, nak);
		chk(d, cmc_pkg::DAC_RST);
		$display("t_pin_reset done");
	endtask : t_pin_reset
	// The pin reset is held low with the power-up reset and released in the same step, before any traffic.
	initial begin
		err_count = 0;
		checks_done = 0;
		we_seen = 1'b0;
		reset = 1'b1;
		rst_n_pin = 1'b0;
		strap0 = 1'b0;
		strap1 = 1'b1;
		repeat (10) @(posedge clk);
		#1;
		reset = 1'b0;
		rst_n_pin = 1'b1;
		repeat (10) @(posedge clk);
		t_addr();
		t_meas();
		t_nvm();
		t_pin_reset();
		report_and_stop();
	end
	initial begin
		#400000;
		err_count++;
		report_and_stop();
	end
endmodule : compass_measurement_control_test
